// ### logic/smc_pkg.sv
// smc_pkg: register indices, field positions, reset values and timing figures
// assumes a 32-bit apb slave where register byte address = 4 * register index
package smc_pkg;
  // register indices (byte address is four times the index)
  localparam logic [7:0] SMC_IDX_SETUP1 = 8'h1d;
  localparam logic [7:0] SMC_IDX_SETUP2 = 8'h1e;
  localparam logic [7:0] SMC_IDX_LIMIT_LO = 8'h1f;
  localparam logic [7:0] SMC_IDX_LEAD_HI = 8'h20;
  localparam logic [7:0] SMC_IDX_LEAD_LO = 8'h21;
  localparam logic [7:0] SMC_IDX_BODY_LEN = 8'h22;
  localparam logic [7:0] SMC_IDX_BODY_CEIL = 8'h23;
  localparam logic [7:0] SMC_IDX_CHG_INT = 8'h24;
  localparam logic [7:0] SMC_IDX_RX_PTR = 8'h25;
  localparam logic [7:0] SMC_IDX_RSVD_LO = 8'h26;
  localparam logic [7:0] SMC_IDX_RSVD_HI = 8'h3f;
  localparam logic [7:0] SMC_IDX_MAN_GAIN = 8'h40;
  localparam logic [7:0] SMC_IDX_IRQ_STAT = 8'h41;
  localparam logic [7:0] SMC_IDX_IRQ_MASK = 8'h42;
  // field positions of the second setup register
  localparam int SMC_SF_LSB = 4;
  localparam int SMC_REPEAT_BIT = 3;
  localparam int SMC_AUTO_GAIN_BIT = 2;
  localparam int SMC_LIMIT_HI_LSB = 0;
  // field positions of the first setup register
  localparam int SMC_HEADERLESS_BIT = 2;
  localparam int SMC_CRC_ON_BIT = 1;
  // reset values
  localparam logic [7:0] SMC_RST_SETUP1 = 8'h00;
  localparam logic [7:0] SMC_RST_SETUP2 = 8'h74;
  localparam logic [7:0] SMC_RST_LIMIT_LO = 8'h64;
  localparam logic [7:0] SMC_RST_LEAD_HI = 8'h00;
  localparam logic [7:0] SMC_RST_LEAD_LO = 8'h08;
  localparam logic [7:0] SMC_RST_BODY_LEN = 8'h01;
  localparam logic [7:0] SMC_RST_BODY_CEIL = 8'hff;
  localparam logic [7:0] SMC_RST_CHG_INT = 8'h00;
  localparam logic [7:0] SMC_RST_MAN_GAIN = 8'h01;
  localparam logic [7:0] SMC_RST_RX_PTR = 8'h00;
  // spreading exponent codes
  localparam logic [3:0] SMC_SF_MIN = 4'h6;
  localparam logic [3:0] SMC_SF_GAP = 4'h9;
  localparam logic [3:0] SMC_SF_MAX = 4'hc;
  // fixed preamble tail of 4.25 symbols, carried in quarter symbols
  localparam logic [17:0] SMC_LEAD_TAIL_QTR = 18'h00011;
  // interrupt status bit positions
  localparam int SMC_IRQ_TIMEOUT = 0;
  localparam int SMC_IRQ_HDR_ERR = 1;
  localparam int SMC_IRQ_HOP = 2;
  localparam int SMC_IRQ_TX_DONE = 3;
  localparam int SMC_IRQ_W = 4;
endpackage

// ### logic/smc_sym_counter.sv
// smc_sym_counter: counts symbol ticks up to a programmed limit
// assumes tick is a one-cycle pulse per symbol period in the pclk domain
`timescale 1ns/10ps
module smc_sym_counter #(
  parameter int W = 10,
  parameter bit RELOAD = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic stop,
  input wire logic tick,
  input wire logic [W-1:0] limit,
  output logic expire,
  output logic active
);
  logic [W-1:0] cnt;
  logic hit;

  // the limit is sampled live so software changes apply at once
  assign hit = active && tick && (cnt + W'(1) == limit);

  // run control: a zero limit never arms the counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active <= 1'b0;
      cnt <= '0;
    end else if (start) begin
      active <= (limit != '0);
      cnt <= '0;
    end else if (stop || (active && limit == '0)) begin
      active <= 1'b0;
    end else if (hit) begin
      active <= RELOAD;
      cnt <= '0;
    end else if (active && tick) begin
      cnt <= cnt + W'(1);
    end
  end

  // expiry pulse, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expire <= 1'b0;
    end else begin
      expire <= hit && !start && !stop;
    end
  end
endmodule

// ### logic/smc_regs.sv
// smc_regs: configuration and status registers of the spread modem, apb slave
// assumes the modem datapath shares pclk and gives one-cycle event pulses
// Operation
// - four-bit spreading exponent, reset seven, reserved codes
// - repeat-send clear: one packet; set: keep sending
// - auto gain one: loop gain; zero: manual gain
// - ten-bit receive symbol timeout, low reset 0x64
// - sixteen-bit lead-in, sent as value plus 4.25
// - header length over ceiling flags header crc error in explicit mode
// - channel change every interval, first after header symbol
// - read-only receive buffer write pointer
// - headerless select picks length source
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
module smc_regs import smc_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sym_tick,
  input wire logic rx_start,
  input wire logic rx_done,
  input wire logic hdr_first_sym,
  input wire logic hdr_valid,
  input wire logic [7:0] hdr_body_len,
  input wire logic rx_byte_wr,
  input wire logic [7:0] rx_byte_addr,
  input wire logic tx_packet_done,
  input wire logic [7:0] loop_gain,
  output logic [3:0] chips_per_symbol_exp,
  output logic [12:0] chips_per_symbol,
  output logic sf_reserved,
  output logic repeat_send_select,
  output logic tx_resend,
  output logic tx_finish,
  output logic auto_gain_select,
  output logic [7:0] front_gain,
  output logic rx_timeout,
  output logic [17:0] lead_in_qtr_symbols,
  output logic headerless_select,
  output logic crc_select,
  output logic [7:0] body_len_used,
  output logic hdr_crc_error,
  output logic channel_change,
  output logic irq
);
  logic [7:0] setup1;
  logic [7:0] setup2;
  logic [7:0] limit_lo;
  logic [7:0] lead_hi;
  logic [7:0] lead_lo;
  logic [7:0] body_len;
  logic [7:0] body_len_ceiling;
  logic [7:0] channel_change_interval;
  logic [7:0] rx_write_pointer;
  logic [7:0] manual_front_gain;
  logic [SMC_IRQ_W-1:0] irq_stat;
  logic [SMC_IRQ_W-1:0] irq_mask;
  logic [SMC_IRQ_W-1:0] irq_set;
  logic [9:0] rx_symbol_limit;
  logic [15:0] lead_in_len;
  logic [7:0] idx;
  logic idx_ok;
  logic wr_en;
  logic rd_en;
  logic [7:0] wbyte;
  logic [31:0] next_prdata;
  logic next_slverr;
  logic tout_pulse;
  logic hop_pulse;
  logic hop_active;
  logic hdr_len_ok;

  // apb decode: word index from byte address, zero-wait answer
  assign idx = paddr[9:2];
  assign idx_ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) &&
                  (idx >= SMC_IDX_SETUP1) && (idx <= SMC_IDX_IRQ_MASK);
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite && idx_ok;
  assign rd_en = psel && !penable && !pwrite;
  assign wbyte = pwdata[7:0];

  // setup registers written through byte lane 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup1 <= SMC_RST_SETUP1;
      setup2 <= SMC_RST_SETUP2;
      limit_lo <= SMC_RST_LIMIT_LO;
      lead_hi <= SMC_RST_LEAD_HI;
      lead_lo <= SMC_RST_LEAD_LO;
      body_len <= SMC_RST_BODY_LEN;
      body_len_ceiling <= SMC_RST_BODY_CEIL;
      channel_change_interval <= SMC_RST_CHG_INT;
      manual_front_gain <= SMC_RST_MAN_GAIN;
    end else if (wr_en && pstrb[0]) begin
      unique case (idx)
        SMC_IDX_SETUP1: setup1 <= wbyte;
        SMC_IDX_SETUP2: setup2 <= wbyte;
        SMC_IDX_LIMIT_LO: limit_lo <= wbyte;
        SMC_IDX_LEAD_HI: lead_hi <= wbyte;
        SMC_IDX_LEAD_LO: lead_lo <= wbyte;
        SMC_IDX_BODY_LEN: body_len <= wbyte;
        SMC_IDX_BODY_CEIL: body_len_ceiling <= wbyte;
        SMC_IDX_CHG_INT: channel_change_interval <= wbyte;
        SMC_IDX_MAN_GAIN: manual_front_gain <= wbyte;
        default: ;
      endcase
    end
  end

  // interrupt mask, same layout as the status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= '0;
    end else if (wr_en && pstrb[0] && idx == SMC_IDX_IRQ_MASK) begin
      irq_mask <= wbyte[SMC_IRQ_W-1:0];
    end
  end

  // receive buffer pointer follows the receiver, software cannot write it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_write_pointer <= SMC_RST_RX_PTR;
    end else if (rx_byte_wr) begin
      rx_write_pointer <= rx_byte_addr;
    end
  end

  // read mux, registered in the setup cycle
  always_comb begin
    next_prdata = '0;
    next_slverr = !idx_ok;
    unique case (idx)
      SMC_IDX_SETUP1: next_prdata[7:0] = setup1;
      SMC_IDX_SETUP2: next_prdata[7:0] = setup2;
      SMC_IDX_LIMIT_LO: next_prdata[7:0] = limit_lo;
      SMC_IDX_LEAD_HI: next_prdata[7:0] = lead_hi;
      SMC_IDX_LEAD_LO: next_prdata[7:0] = lead_lo;
      SMC_IDX_BODY_LEN: next_prdata[7:0] = body_len;
      SMC_IDX_BODY_CEIL: next_prdata[7:0] = body_len_ceiling;
      SMC_IDX_CHG_INT: next_prdata[7:0] = channel_change_interval;
      SMC_IDX_RX_PTR: next_prdata[7:0] = rx_write_pointer;
      SMC_IDX_MAN_GAIN: next_prdata[7:0] = manual_front_gain;
      SMC_IDX_IRQ_STAT: next_prdata[SMC_IRQ_W-1:0] = irq_stat;
      SMC_IDX_IRQ_MASK: next_prdata[SMC_IRQ_W-1:0] = irq_mask;
      default: next_prdata = '0; // reserved space reads zero
    endcase
  end

  // read data and error flag held through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= rd_en ? next_prdata : 32'h0000_0000;
      pslverr <= next_slverr;
    end
  end

  // spreading exponent and chip count per symbol
  assign chips_per_symbol_exp = setup2[SMC_SF_LSB +: 4];
  assign sf_reserved = (chips_per_symbol_exp < SMC_SF_MIN) ||
                       (chips_per_symbol_exp == SMC_SF_GAP) ||
                       (chips_per_symbol_exp > SMC_SF_MAX);
  assign chips_per_symbol = sf_reserved ? 13'h0000 :
                            (13'h0001 << chips_per_symbol_exp);

  // transmit repeat control
  assign repeat_send_select = setup2[SMC_REPEAT_BIT];

  // after each packet either send the buffer again or finish
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_resend <= 1'b0;
      tx_finish <= 1'b0;
    end else begin
      tx_resend <= tx_packet_done && repeat_send_select;
      tx_finish <= tx_packet_done && !repeat_send_select;
    end
  end

  // front-end gain source
  assign auto_gain_select = setup2[SMC_AUTO_GAIN_BIT];

  // gain value handed to the front end, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      front_gain <= SMC_RST_MAN_GAIN;
    end else begin
      front_gain <= auto_gain_select ? loop_gain : manual_front_gain;
    end
  end

  // split fields joined from live register contents
  assign rx_symbol_limit = {setup2[SMC_LIMIT_HI_LSB +: 2], limit_lo};
  assign lead_in_len = {lead_hi, lead_lo};

  // total preamble in quarter symbols: length plus 4.25
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lead_in_qtr_symbols <= '0;
    end else begin
      lead_in_qtr_symbols <= {lead_in_len, 2'b00} + SMC_LEAD_TAIL_QTR;
    end
  end

  // receive timeout in symbol periods
  smc_sym_counter #(.W(10), .RELOAD(1'b0)) u_timeout (
    .pclk(pclk),
    .presetn(presetn),
    .start(rx_start),
    .stop(rx_done),
    .tick(sym_tick),
    .limit(rx_symbol_limit),
    .expire(tout_pulse),
    .active()
  );
  assign rx_timeout = tout_pulse;

  // channel change period, armed at the first header symbol
  smc_sym_counter #(.W(8), .RELOAD(1'b1)) u_hop (
    .pclk(pclk),
    .presetn(presetn),
    .start(hdr_first_sym),
    .stop(rx_done),
    .tick(sym_tick),
    .limit(channel_change_interval),
    .expire(hop_pulse),
    .active(hop_active)
  );

  // first change right after the first header symbol, then periodic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_change <= 1'b0;
    end else begin
      channel_change <= (hdr_first_sym && channel_change_interval != 8'h00) ||
                        (hop_pulse && hop_active);
    end
  end

  // header mode and length source
  assign headerless_select = setup1[SMC_HEADERLESS_BIT];
  assign crc_select = setup1[SMC_CRC_ON_BIT];
  assign hdr_len_ok = hdr_body_len <= body_len_ceiling;

  // header length check against the ceiling, explicit mode only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdr_crc_error <= 1'b0;
    end else begin
      hdr_crc_error <= hdr_valid && !headerless_select && !hdr_len_ok;
    end
  end

  // length used by the receiver: register when headerless, header otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      body_len_used <= SMC_RST_BODY_LEN;
    end else if (headerless_select) begin
      body_len_used <= body_len;
    end else if (hdr_valid) begin
      body_len_used <= hdr_body_len;
    end
  end

  // events feeding the sticky status bits
  always_comb begin
    irq_set = '0;
    irq_set[SMC_IRQ_TIMEOUT] = rx_timeout;
    irq_set[SMC_IRQ_HDR_ERR] = hdr_crc_error;
    irq_set[SMC_IRQ_HOP] = channel_change;
    irq_set[SMC_IRQ_TX_DONE] = tx_finish;
  end

  // sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
    end else if (wr_en && pstrb[0] && idx == SMC_IDX_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~wbyte[SMC_IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat <= irq_stat | irq_set;
    end
  end

  // level interrupt while any unmasked status bit is set
  assign irq = |(irq_stat & irq_mask);
endmodule

// ### tb/smc_regs_props.sv
// smc_regs_props: port-level checks of smc_regs
// assumes one pclk domain, presetn low resets everything
`timescale 1ns/10ps
module smc_regs_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_packet_done,
  input wire logic repeat_send_select,
  input wire logic tx_resend,
  input wire logic tx_finish,
  input wire logic [3:0] chips_per_symbol_exp,
  input wire logic [12:0] chips_per_symbol,
  input wire logic sf_reserved,
  input wire logic auto_gain_select,
  input wire logic [7:0] loop_gain,
  input wire logic [7:0] front_gain,
  input wire logic hdr_valid,
  input wire logic headerless_select,
  input wire logic hdr_crc_error,
  input wire logic [17:0] lead_in_qtr_symbols,
  input wire logic rx_timeout,
  input wire logic sym_tick,
  input wire logic channel_change,
  input wire logic hdr_first_sym
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // a packet end gives exactly one outcome a cycle later
  sequence s_fin;
    ##1 (tx_finish && !tx_resend);
  endsequence
  sequence s_res;
    ##1 (tx_resend && !tx_finish);
  endsequence
  property p_sf_dec;
    !sf_reserved |-> chips_per_symbol == 13'(1 << chips_per_symbol_exp);
  endproperty
  a_sf_dec: assert property (p_sf_dec) else $error("chip count wrong");
  property p_resend;
    tx_packet_done && repeat_send_select |-> s_res;
  endproperty
  a_resend: assert property (p_resend) else $error("no resend");
  property p_finish;
    tx_packet_done && !repeat_send_select |-> s_fin;
  endproperty
  a_finish: assert property (p_finish) else $error("no finish");
  property p_gain;
    auto_gain_select |=> front_gain == $past(loop_gain);
  endproperty
  a_gain: assert property (p_gain) else $error("gain not from loop");
  property p_crc;
    hdr_crc_error |-> $past(hdr_valid) && !$past(headerless_select);
  endproperty
  a_crc: assert property (p_crc) else $error("stray header error");
  property p_lead;
    $past(presetn) |-> lead_in_qtr_symbols[1:0] == 2'b01;
  endproperty
  a_lead: assert property (p_lead) else $error("lead-in tail wrong");
  property p_tmo;
    rx_timeout |-> $past(sym_tick) || $past(sym_tick, 2);
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout without tick");
  property p_hop;
    channel_change |-> $past(hdr_first_sym) || $past(sym_tick, 2);
  endproperty
  a_hop: assert property (p_hop) else $error("change without cause");
endmodule
bind smc_regs smc_regs_props u_props (.*);

// ### tb/tb_top.sv
// tb_top: self-checking bench for smc_regs over apb
// assumes smc_pkg and the bound checker are compiled first
`timescale 1ns/10ps
module tb_top;
  import smc_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'hf;
  logic [6:0] ev = '0;
  logic [7:0] hdr_body_len = '0;
  logic [7:0] rx_byte_addr = '0;
  logic [7:0] loop_gain = '0;
  wire logic rx_byte_wr, sym_tick, rx_start, rx_done, hdr_first_sym, hdr_valid, tx_packet_done;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, sf_reserved, repeat_send_select, tx_resend, tx_finish;
  logic auto_gain_select, rx_timeout, headerless_select, crc_select, hdr_crc_error;
  logic channel_change, irq;
  logic [3:0] chips_per_symbol_exp;
  logic [12:0] chips_per_symbol;
  logic [7:0] front_gain, body_len_used, x, y;
  logic [17:0] lead_in_qtr_symbols;
  logic [7:0] ri [12] = '{8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25,
    8'h40, 8'h41, 8'h42};
  logic [7:0] rv [12] = '{8'h0, 8'h74, 8'h64, 8'h0, 8'h8, 8'h1, 8'hff, 8'h0, 8'h0, 8'h1,
    8'h0, 8'h0};
  int fails = 0;
  int check_count = 0;
  int n_to = 0;
  int n_crc = 0;
  int n_cc = 0;
  assign {rx_byte_wr, sym_tick, rx_start, rx_done, hdr_first_sym, hdr_valid, tx_packet_done} = ev;
  always #20 pclk = ~pclk;
  smc_regs uut (.*);
  // counts of the one-cycle event outputs
  always @(posedge pclk) begin
    if (rx_timeout === 1'b1) n_to <= n_to + 1;
    if (hdr_crc_error === 1'b1) n_crc <= n_crc + 1;
    if (channel_change === 1'b1) n_cc <= n_cc + 1;
  end
  function automatic logic [12:0] exp_chips(input int c);
    return (c inside {6, 7, 8, 10, 11, 12}) ? 13'(1 << c) : 13'h0;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one apb transfer by register index, waiting for pready
  task automatic apb(input logic [7:0] idx, input logic wr, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      fails++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  // one-cycle pulse on the selected event inputs
  task automatic pulse(input logic [6:0] m);
    @(posedge pclk);
    ev <= m;
    @(posedge pclk);
    ev <= '0;
    #1;
  endtask
  initial begin
    void'($urandom(32'h4de67632));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      apb(ri[i], 1'b0, 32'h0);
      chk(rd, {24'h0, rv[i]});
    end
    // random write and read back; body length kept nonzero
    for (int i = 2; i < 10; i++) begin
      x = 8'($urandom_range(255, 1));
      apb(ri[i], 1'b1, {24'h0, x});
      apb(ri[i], 1'b0, 32'h0);
      chk(rd, (i == 8) ? 32'h0 : {24'h0, x});
    end
    apb(8'h30, 1'b1, 32'h5a);
    apb(8'h30, 1'b0, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h0);
    apb(8'h50, 1'b0, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int c = 0; c < 16; c++) begin
      apb(8'h1e, 1'b1, {24'h0, 4'(c), 4'h4});
      chk({19'h0, chips_per_symbol}, {19'h0, exp_chips(c)});
      chk({31'h0, sf_reserved}, {31'h0, exp_chips(c) == 13'h0});
      chk({28'h0, chips_per_symbol_exp}, 32'(c));
    end
    for (int m = 0; m < 4; m++) begin
      x = 8'($urandom);
      y = 8'($urandom);
      @(posedge pclk) loop_gain <= y;
      apb(8'h40, 1'b1, {24'h0, x});
      apb(8'h1e, 1'b1, {24'h0, 4'h7, 2'(m), 2'b00});
      pulse(7'h01);
      chk({30'h0, tx_resend, tx_finish}, m[1] ? 32'h2 : 32'h1);
      chk({24'h0, front_gain}, {24'h0, m[0] ? y : x});
      chk({30'h0, repeat_send_select, auto_gain_select}, 32'(m));
    end
    @(posedge pclk) rx_byte_addr <= 8'($urandom);
    pulse(7'h40);
    apb(8'h25, 1'b0, 32'h0);
    chk(rd, {24'h0, rx_byte_addr});
    x = 8'($urandom);
    y = 8'($urandom);
    apb(8'h20, 1'b1, {24'h0, x});
    apb(8'h21, 1'b1, {24'h0, y});
    repeat (2) @(posedge pclk);
    #1 chk({14'h0, lead_in_qtr_symbols}, 32'({x, y}) * 4 + 17);
    // receive timeout of three symbols raises, masks and clears irq
    apb(8'h41, 1'b1, 32'hf);
    apb(8'h42, 1'b1, 32'h1);
    apb(8'h1e, 1'b1, 32'h74);
    apb(8'h1f, 1'b1, 32'h3);
    pulse(7'h10);
    pulse(7'h20);
    pulse(7'h20);
    repeat (3) @(posedge pclk);
    #1 chk(n_to, 0);
    pulse(7'h20);
    repeat (3) @(posedge pclk);
    #1 chk(n_to, 1);
    chk({31'h0, irq}, 32'h1);
    apb(8'h41, 1'b0, 32'h0);
    chk(rd, 32'h1);
    apb(8'h42, 1'b1, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(8'h42, 1'b1, 32'h1);
    apb(8'h41, 1'b1, 32'h1);
    chk({31'h0, irq}, 32'h0);
    pulse(7'h08);
    // header length just below, at and above the ceiling
    apb(8'h1d, 1'b1, 32'h0);
    x = 8'($urandom_range(254, 1));
    apb(8'h23, 1'b1, {24'h0, x});
    for (int k = 0; k < 3; k++) begin
      @(posedge pclk) hdr_body_len <= x + 8'(k) - 8'h1;
      pulse(7'h02);
      @(posedge pclk);
      #1 chk(n_crc, k / 2);
      chk({24'h0, body_len_used}, {24'h0, hdr_body_len});
    end
    apb(8'h1d, 1'b1, 32'h6);
    chk({30'h0, headerless_select, crc_select}, 32'h3);
    apb(8'h22, 1'b1, 32'h5);
    pulse(7'h02);
    @(posedge pclk);
    #1 chk(n_crc, 1);
    chk({24'h0, body_len_used}, 32'h5);
    // hopping off, then every two symbols
    apb(8'h24, 1'b1, 32'h0);
    pulse(7'h10);
    pulse(7'h04);
    pulse(7'h20);
    pulse(7'h20);
    pulse(7'h08);
    chk(n_cc, 0);
    apb(8'h24, 1'b1, 32'h2);
    pulse(7'h10);
    pulse(7'h04);
    chk({31'h0, channel_change}, 32'h1);
    repeat (4) pulse(7'h20);
    repeat (2) @(posedge pclk);
    #1 chk(n_cc, 3);
    pulse(7'h08);
    // reset in mid-run brings back the defaults
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(8'h1e, 1'b0, 32'h0);
    chk(rd, 32'h74);
    apb(8'h41, 1'b0, 32'h0);
    chk(rd, 32'h0);
    results();
  end
endmodule
